// *** core/dac_update_clear_control.sv ***
// Overview of operation
// - Clear pin low forces buffer and latch to clear value.
// - Clear mode ends at next valid write's frame end.
// - Clear during a frame acts at once.
// - Software clear bit clears latch at frame end.
// - Separate input buffer and output latch.
// - Update-mode bit selects synchronous or asynchronous updating.
// - Synchronous mode: load pulse copies buffer to latch.
// - Load pulse without new buffer data changes nothing.
// - Asynchronous, chain enabled: update at frame end.
// - Asynchronous, chain disabled: update at 32nd falling edge.
// - Software reset bit restores power-on defaults except pin synchronisers and edge history.
// - Bit 31 is direction, next seven bits address.
// - No-operation register write stores nothing but still ends clear mode.
// - Code register holds 20-bit code in bits 23-4.
// - Each access is one 32-bit select-framed frame.
// - Sample inputs on falling, shift outputs on rising edges.
module dac_update_clear_control (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic frame_select_n_i,
	input wire logic serial_clk_i,
	input wire logic serial_data_i,
	input wire logic clear_input_n_i,
	input wire logic load_strobe_n_i,
	output logic serial_data_o,
	output logic serial_data_oe_o,
	output logic [19:0] dac_code_o,
	output logic clear_mode_o
);

	// Synchronised pin levels, packed in one group for the synchroniser.
	// Every level lags its pin by two system clocks, which is why each serial
	// clock phase must last at least three system periods.
	logic [4:0] pins_sync;
	wire logic frame_n_s = pins_sync[4];
	wire logic sclk_s = pins_sync[3];
	wire logic sdi_s = pins_sync[2];
	wire logic clear_n_s = pins_sync[1];
	wire logic load_n_s = pins_sync[0];

	// Frame engine results.
	logic [31:0] word;
	logic frame_done;
	logic last_edge;
	logic shifter_sdo;

	// Input buffer and output latch kept apart so a write does not move the output.
	logic [19:0] buffer_reg;
	logic [19:0] buffer_next;
	logic [19:0] latch_reg;
	logic [19:0] latch_next;
	// Buffer written since the last load-pulse update.
	logic dirty_reg;
	// Clear mode, entered by the clear pin.
	logic clear_mode_reg;
	// Configuration and clear-value storage.
	logic [23:0] primary_configuration_reg;
	logic [23:0] secondary_configuration_reg;
	logic [7:0] clear_value_reg;
	// One-cycle soft reset, raised by the trigger register.
	logic soft_rst_reg;
	// Load pin history, for finding the start of a load pulse.
	logic load_prev_reg;
	// A readback word waits in the shifter for the next frame.
	logic read_pending_reg;
	logic sdo_oe_reg;
	logic [23:0] read_data;

	// Address match, used by every register decode below.
	// A function keeps the write decode and the readback mux on one compare.
	function automatic logic hit(input logic [6:0] addr, input logic [6:0] target);
		hit = (addr == target);
	endfunction

	// All pins arrive from the host, so every one passes two flip-flops first.
	// The start levels match the idle pins (select high, serial clock and data
	// low, clear and load released), so no false edge follows reset.
	pin_sync #(
		.WIDTH(5),
		.INIT(5'h13)
	) u_pin_sync (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.pins_i({frame_select_n_i, serial_clk_i, serial_data_i, clear_input_n_i,
			load_strobe_n_i}),
		.pins_o(pins_sync)
	);

	// The fields are read straight from the shift register and only mean
	// something once the last bit is in, so every strobe that reads them is gated by the done or last-edge pulse.
	// Frame decode: direction bit, address and payload.
	wire logic is_read_bit = word[dac_ctrl_pkg::RW_BIT];
	wire logic [6:0] addr = word[dac_ctrl_pkg::ADDR_HI:dac_ctrl_pkg::ADDR_LO];
	wire logic [23:0] payload = word[dac_ctrl_pkg::DATA_HI:0];
	wire logic wr_done = frame_done && !is_read_bit;
	wire logic rd_done = frame_done && is_read_bit;
	wire logic code_in_word = !is_read_bit && hit(addr, dac_ctrl_pkg::ADDR_CODE);
	// Writes to the no-operation address match none of these, but still end clear mode.
	wire logic wr_code = wr_done && code_in_word;
	wire logic wr_primary_configuration = wr_done && hit(addr, dac_ctrl_pkg::ADDR_PRIMARY_CONFIGURATION);
	wire logic wr_clear = wr_done && hit(addr, dac_ctrl_pkg::ADDR_CLEAR);
	wire logic wr_secondary_configuration = wr_done && hit(addr, dac_ctrl_pkg::ADDR_SECONDARY_CONFIGURATION);
	wire logic wr_trigger = wr_done && hit(addr, dac_ctrl_pkg::ADDR_TRIGGER);
	wire logic sw_clear = wr_trigger && payload[dac_ctrl_pkg::SW_CLEAR_BIT];
	wire logic sw_reset = wr_trigger && payload[dac_ctrl_pkg::SW_RESET_BIT];

	// Code carried by the frame, taken from bits 23 to 4.
	wire logic [19:0] word_code = payload[dac_ctrl_pkg::CODE_HI:dac_ctrl_pkg::CODE_LO];
	// Clear value widened to a full code, lower bits zero.
	wire logic [19:0] clear_code = {clear_value_reg, {dac_ctrl_pkg::CLEAR_PAD{1'b0}}};
	// Newest code: a code carried by the current frame wins over the buffer.
	wire logic [19:0] newest_code = code_in_word ? word_code : buffer_reg;

	// Update mode selection.
	wire logic sync_mode = primary_configuration_reg[dac_ctrl_pkg::UPDATE_MODE_BIT];
	wire logic sdo_disabled = primary_configuration_reg[dac_ctrl_pkg::SDO_DISABLE_BIT];
	wire logic clear_pin = !clear_n_s;
	// Leaving clear mode needs a valid write with the pin released.
	wire logic clear_exit = clear_mode_reg && wr_done && !clear_pin;
	// Asynchronous update points: frame end with chain enabled, 32nd edge without.
	wire logic async_at_end = !sync_mode && !sdo_disabled && frame_done;
	wire logic async_at_edge = !sync_mode && sdo_disabled && last_edge;
	// Leaving clear mode in asynchronous mode lets the newest code through at
	// once; with the chain off the 32nd edge fell while the latch was still
	// held, so the exit frame end is the only point left to apply it.
	wire logic exit_update = clear_exit && !sync_mode;
	// In asynchronous mode the load pin is assumed tied low and is not looked at.
	wire logic load_fall = load_prev_reg && !load_n_s;
	// Only the falling edge counts, so a pulse acts once whatever its length,
	// provided it spans at least two system clocks.
	// A load pulse only moves the output when the buffer holds new data.
	wire logic sync_update = sync_mode && load_fall && dirty_reg;
	// The host is trusted to have finished its buffer write before the pulse.

	// Serial shifter and frame engine.
	// Its edges lag the real serial clock by about three system cycles.
	serial_frame_shifter u_shifter (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.soft_rst_i(soft_rst_reg),
		.sclk_i(sclk_s),
		.frame_n_i(frame_n_s),
		.sdi_i(sdi_s),
		.load_i(rd_done),
		.load_word_i({1'b1, addr, read_data}),
		.shift_o(word),
		.frame_done_o(frame_done),
		.last_edge_o(last_edge),
		.sdo_o(shifter_sdo)
	);

	// Readback mux; trigger bits always read zero because they are one-shot.
	// Unknown and write-only addresses read as zero, so no stale bits of
	// another register ever reach the host.
	assign read_data =
		hit(addr, dac_ctrl_pkg::ADDR_CODE) ? {buffer_reg, 4'h0} :
		hit(addr, dac_ctrl_pkg::ADDR_PRIMARY_CONFIGURATION) ? primary_configuration_reg :
		hit(addr, dac_ctrl_pkg::ADDR_CLEAR) ?
			{clear_value_reg, {dac_ctrl_pkg::CLEAR_LO{1'b0}}} :
		hit(addr, dac_ctrl_pkg::ADDR_STATUS) ? dac_ctrl_pkg::STATUS_VALUE :
		hit(addr, dac_ctrl_pkg::ADDR_SECONDARY_CONFIGURATION) ? secondary_configuration_reg :
		24'h00_0000;

	// Buffer: the clear pin overrides everything, even mid-frame.
	// Only a complete write frame reaches the buffer; short frames leave it alone.
	assign buffer_next = clear_pin ? clear_code :
		wr_code ? word_code :
		buffer_reg;

	// Latch priority: clear pin, software clear, clear-mode hold, then updates.
	// Both clears beat the updates, so a frame that ends while the output is
	// being cleared cannot overwrite the clear code.
	assign latch_next = clear_pin ? clear_code :
		sw_clear ? clear_code :
		(clear_mode_reg && !clear_exit) ? latch_reg :
		(async_at_end || async_at_edge || exit_update) ? newest_code :
		sync_update ? buffer_reg :
		latch_reg;

	// Code path registers; the soft reset pulse brings back power-on values.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			buffer_reg <= dac_ctrl_pkg::CODE_RESET;
			latch_reg <= dac_ctrl_pkg::CODE_RESET;
		end else if (soft_rst_reg) begin
			buffer_reg <= dac_ctrl_pkg::CODE_RESET;
			latch_reg <= dac_ctrl_pkg::CODE_RESET;
		end else begin
			buffer_reg <= buffer_next;
			latch_reg <= latch_next;
		end
	end

	// New-data flag: a buffer write sets it and wins over a clearing update.
	// Asynchronous updates leave it set; the latch already matches the buffer
	// then, so a load pulse after a change of mode copies the same code.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			dirty_reg <= 1'b0;
		end else if (soft_rst_reg) begin
			dirty_reg <= 1'b0;
		end else if (wr_code) begin
			dirty_reg <= 1'b1;
		end else if (sync_update) begin
			dirty_reg <= 1'b0;
		end
	end

	// Clear mode: the pin sets it and wins over an exiting write.
	// A soft reset drops it even with the pin low; the pin sets it again on
	// the next cycle, so the pin still has the last word.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			clear_mode_reg <= 1'b0;
		end else if (soft_rst_reg) begin
			clear_mode_reg <= 1'b0;
		end else if (clear_pin) begin
			clear_mode_reg <= 1'b1;
		end else if (clear_exit) begin
			clear_mode_reg <= 1'b0;
		end
	end

	// Configuration registers keep only their writable bits.
	// Masking on write keeps reserved bits at zero, so readback shows only
	// what the hardware really holds.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			primary_configuration_reg <= dac_ctrl_pkg::PRIMARY_CONFIGURATION_RESET;
			secondary_configuration_reg <= dac_ctrl_pkg::SECONDARY_CONFIGURATION_RESET;
			clear_value_reg <= dac_ctrl_pkg::CLEAR_RESET;
		end else if (soft_rst_reg) begin
			primary_configuration_reg <= dac_ctrl_pkg::PRIMARY_CONFIGURATION_RESET;
			secondary_configuration_reg <= dac_ctrl_pkg::SECONDARY_CONFIGURATION_RESET;
			clear_value_reg <= dac_ctrl_pkg::CLEAR_RESET;
		end else begin
			if (wr_primary_configuration) begin
				primary_configuration_reg <= payload & dac_ctrl_pkg::PRIMARY_CONFIGURATION_WMASK;
			end
			if (wr_secondary_configuration) begin
				secondary_configuration_reg <= payload & dac_ctrl_pkg::SECONDARY_CONFIGURATION_WMASK;
			end
			if (wr_clear) begin
				clear_value_reg <= payload[dac_ctrl_pkg::DATA_HI:dac_ctrl_pkg::CLEAR_LO];
			end
		end
	end

	// Software reset is a single-cycle pulse, so the trigger never stays set.
	// It comes one cycle after the trigger frame completes. The synchronisers
	// and the load pin history are left alone on purpose, so a pin held low
	// is not taken for a fresh edge afterwards.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			soft_rst_reg <= 1'b0;
		end else begin
			soft_rst_reg <= sw_reset;
		end
	end

	// Load pin history; its idle level is high in synchronous use.
	// A pin held low, as asynchronous mode wants, therefore never acts again.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			load_prev_reg <= 1'b1;
		end else begin
			load_prev_reg <= load_n_s;
		end
	end

	// Serial output is driven during frames when the chain output is on, or
	// when a readback is waiting; this keeps reads working with the chain off.
	// Limitation: a short frame after a read does not end the pending state,
	// so the output stays enabled until a complete frame arrives.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			read_pending_reg <= 1'b0;
			sdo_oe_reg <= 1'b0;
		end else if (soft_rst_reg) begin
			read_pending_reg <= 1'b0;
			sdo_oe_reg <= 1'b0;
		end else begin
			if (rd_done) begin
				read_pending_reg <= 1'b1;
			end else if (frame_done) begin
				read_pending_reg <= 1'b0;
			end
			sdo_oe_reg <= !frame_n_s && (!sdo_disabled || read_pending_reg);
		end
	end

	assign serial_data_o = shifter_sdo;
	assign serial_data_oe_o = sdo_oe_reg;
	assign dac_code_o = latch_reg;
	assign clear_mode_o = clear_mode_reg;

endmodule // dac_update_clear_control

// *** core/dac_ctrl_pkg.sv ***
// Shared constants for the converter control core: frame layout, register
// addresses, field positions and reset values.
package dac_ctrl_pkg;

	// A complete serial access has at least this many bits; longer daisy-chain frames saturate the count.
	localparam logic [5:0] FRAME_BITS = 6'h20;
	// Bit count value seen just before the last bit of a frame is shifted in.
	localparam logic [5:0] FRAME_LAST = 6'h1F;

	// Frame layout: direction bit, address field, register payload.
	localparam int RW_BIT = 31;
	localparam int ADDR_HI = 30;
	localparam int ADDR_LO = 24;
	localparam int DATA_HI = 23;
	localparam int ADDR_W = 7;
	localparam int REG_W = 24;

	// Output code: 20 bits, MSB aligned inside the 24-bit payload.
	localparam int CODE_W = 20;
	localparam int CODE_HI = 23;
	localparam int CODE_LO = 4;
	// Clear value: 8 bits sitting at the top of the payload and of the code.
	localparam int CLEAR_W = 8;
	localparam int CLEAR_LO = 16;
	localparam int CLEAR_PAD = CODE_W - CLEAR_W;

	// Register addresses.
	localparam logic [6:0] ADDR_NOP = 7'h00;
	localparam logic [6:0] ADDR_CODE = 7'h01;
	localparam logic [6:0] ADDR_PRIMARY_CONFIGURATION = 7'h02;
	localparam logic [6:0] ADDR_CLEAR = 7'h03;
	localparam logic [6:0] ADDR_TRIGGER = 7'h04;
	localparam logic [6:0] ADDR_STATUS = 7'h05;
	localparam logic [6:0] ADDR_SECONDARY_CONFIGURATION = 7'h06;

	// Field positions.
	localparam int UPDATE_MODE_BIT = 14;
	localparam int SDO_DISABLE_BIT = 11;
	localparam int SW_RESET_BIT = 6;
	localparam int SW_CLEAR_BIT = 5;

	// Reset values and masks of the bits that software may change.
	localparam logic [23:0] PRIMARY_CONFIGURATION_RESET = 24'h00_4C80;
	localparam logic [23:0] PRIMARY_CONFIGURATION_WMASK = 24'h8C_7FD0;
	localparam logic [23:0] SECONDARY_CONFIGURATION_RESET = 24'h00_0000;
	localparam logic [23:0] SECONDARY_CONFIGURATION_WMASK = 24'h00_00B0;
	localparam logic [23:0] STATUS_VALUE = 24'h00_0000;
	localparam logic [19:0] CODE_RESET = 20'h0_0000;
	localparam logic [7:0] CLEAR_RESET = 8'h00;

endpackage

// *** core/pin_sync.sv ***
// Two flip-flop synchroniser for a group of pins from outside the clock domain.
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] pins_i,
	output logic [WIDTH-1:0] pins_o
);

	// First stage; only the second stage reads it, to keep metastability contained.
	logic [WIDTH-1:0] meta_reg;
	// Second stage, safe for any logic to read.
	logic [WIDTH-1:0] safe_reg;

	// Both stages start at the idle levels of the pins.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			meta_reg <= INIT;
			safe_reg <= INIT;
		end else begin
			meta_reg <= pins_i;
			safe_reg <= meta_reg;
		end
	end

	assign pins_o = safe_reg;

endmodule // pin_sync

// *** core/serial_frame_shifter.sv ***
// Serial frame engine: finds serial clock and frame select edges in the system
// clock domain, shifts bits in and out and reports frame events.
module serial_frame_shifter (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic soft_rst_i,
	input wire logic sclk_i,
	input wire logic frame_n_i,
	input wire logic sdi_i,
	input wire logic load_i,
	input wire logic [31:0] load_word_i,
	output logic [31:0] shift_o,
	output logic frame_done_o,
	output logic last_edge_o,
	output logic sdo_o
);

	// Previous samples of the synchronised pins, used for edge detection.
	logic sclk_prev_reg;
	logic frame_prev_reg;
	// Shift register, bit counter and event pulses.
	logic [31:0] shift_reg;
	logic [5:0] count_reg;
	logic done_reg;
	logic last_reg;
	logic sdo_reg;

	// Edge decoding of the sampled pins.
	wire logic active = !frame_n_i;
	wire logic frame_start = frame_prev_reg && !frame_n_i;
	wire logic frame_end = !frame_prev_reg && frame_n_i;
	wire logic sclk_fall = active && sclk_prev_reg && !sclk_i;
	wire logic sclk_rise = active && !sclk_prev_reg && sclk_i;
	wire logic [5:0] count_inc = (count_reg == dac_ctrl_pkg::FRAME_BITS) ?
		count_reg : count_reg + 6'h01;

	// Edge history follows the pins every cycle.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sclk_prev_reg <= 1'b0;
			frame_prev_reg <= 1'b1;
		end else begin
			sclk_prev_reg <= sclk_i;
			frame_prev_reg <= frame_n_i;
		end
	end

	// Input bits enter on falling serial clock edges; a readback word is loaded
	// between frames so the next frame clocks it out.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			shift_reg <= '0;
		end else if (soft_rst_i) begin
			shift_reg <= '0;
		end else if (sclk_fall) begin
			shift_reg <= {shift_reg[30:0], sdi_i};
		end else if (load_i && !active) begin
			shift_reg <= load_word_i;
		end
	end

	// Bits are counted from the frame start and the count saturates, so extra
	// bits of a daisy chain ripple through without wrapping the count.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			count_reg <= '0;
		end else if (soft_rst_i || frame_start) begin
			count_reg <= '0;
		end else if (sclk_fall) begin
			count_reg <= count_inc;
		end
	end

	// A frame only counts when 32 or more bits arrived, as the count saturates; the last-edge pulse
	// follows the 32nd falling edge, when the shift register is complete.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			done_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			done_reg <= frame_end && (count_reg == dac_ctrl_pkg::FRAME_BITS);
			last_reg <= sclk_fall && (count_reg == dac_ctrl_pkg::FRAME_LAST);
		end
	end

	// Output bits change on rising serial clock edges.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sdo_reg <= 1'b0;
		end else if (soft_rst_i) begin
			sdo_reg <= 1'b0;
		end else if (sclk_rise) begin
			sdo_reg <= shift_reg[31];
		end
	end

	assign shift_o = shift_reg;
	assign frame_done_o = done_reg;
	assign last_edge_o = last_reg;
	assign sdo_o = sdo_reg;

endmodule // serial_frame_shifter

// *** sim/dac_update_clear_control_sva.sv ***
// Watches the converter control pins: clear mode, latch stability and framing.
module dac_update_clear_control_sva (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic frame_select_n_i,
	input wire logic serial_clk_i,
	input wire logic serial_data_i,
	input wire logic clear_input_n_i,
	input wire logic load_strobe_n_i,
	input wire logic serial_data_o,
	input wire logic serial_data_oe_o,
	input wire logic [19:0] dac_code_o,
	input wire logic clear_mode_o
);
	// All checks live in the system clock domain and pause during reset.
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	chk_reset_state: assert property (
		$past(rst_i) |-> dac_code_o == 20'h0_0000 && !clear_mode_o)
		else $error("Latch or clear flag not cleared after reset.");
	// Pin delay is two flops plus the clear-mode register, so six low samples are plenty.
	chk_clear_entry: assert property (
		!clear_input_n_i [*6] |-> clear_mode_o)
		else $error("Clear pin low without clear mode.");
	chk_clear_freeze: assert property (
		!clear_input_n_i [*7] |-> $stable(dac_code_o))
		else $error("Latch moved while clear pin low.");
	chk_clear_pad: assert property (
		!clear_input_n_i [*7] |-> dac_code_o[11:0] == 12'h000)
		else $error("Clear code has nonzero low bits.");
	chk_clear_exit: assert property (
		$fell(clear_mode_o) |-> frame_select_n_i && !$past(frame_select_n_i, 8) && clear_input_n_i)
		else $error("Clear mode left outside a frame end.");
	chk_clear_cause: assert property (
		$rose(clear_mode_o) |-> !$past(clear_input_n_i, 2))
		else $error("Clear mode entered without the pin.");
	// With no frame, clear or load activity the converter code must not move.
	chk_code_quiet: assert property (
		(frame_select_n_i && clear_input_n_i && $stable(load_strobe_n_i)) [*8]
		|-> $stable(dac_code_o))
		else $error("Latch changed with no update event.");
	chk_oe_idle: assert property (
		frame_select_n_i [*5] |-> !serial_data_oe_o)
		else $error("Serial output driven outside a frame.");

	// Main scenarios seen.
	cov_clear_enter: cover property ($rose(clear_mode_o));
	cov_clear_leave: cover property ($fell(clear_mode_o));
	cov_mid_frame_update: cover property (!frame_select_n_i && $changed(dac_code_o));
endmodule // dac_update_clear_control_sva

bind dac_update_clear_control dac_update_clear_control_sva i_chk (
	.clk_sys_i(clk_sys_i), .rst_i(rst_i), .frame_select_n_i(frame_select_n_i),
	.serial_clk_i(serial_clk_i), .serial_data_i(serial_data_i),
	.clear_input_n_i(clear_input_n_i), .load_strobe_n_i(load_strobe_n_i),
	.serial_data_o(serial_data_o), .serial_data_oe_o(serial_data_oe_o),
	.dac_code_o(dac_code_o), .clear_mode_o(clear_mode_o));

// *** sim/host_serial_model.sv ***
// Host end of the serial link; every pin change lands on a falling system edge.
module host_serial_model (
	input wire logic clk_i,
	input wire logic sdo_i,
	output logic frame_n_o,
	output logic sclk_o,
	output logic sdi_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle link: select high, serial clock parked low between frames.
	initial begin
		frame_n_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o = 1'b0;
	end

	task automatic gap(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	// Sends the top n bits of w, MSB first; tail keeps select low after the last bit.
	// Four system cycles per clock phase give the 200 ns serial period.
	task automatic frame(input logic [31:0] w, input int n, input int tail,
			output logic [31:0] r);
		r = 32'h0000_0000;
		gap(1);
		frame_n_o = 1'b0;
		for (int i = 31; i > 31 - n; i--) begin
			gap(2);
			sdi_o = w[i];
			gap(2);
			sclk_o = 1'b1;
			gap(4);
			r[i] = sdo_i;
			sclk_o = 1'b0;
		end
		gap(4 + tail);
		frame_n_o = 1'b1;
		// Released data line shows the inverse so stale bits cannot pass.
		sdi_o = ~sdi_o;
		gap(8);
	endtask
endmodule // host_serial_model

// *** sim/tb.sv ***
// Self-checking bench: register frames, load pulses and clear pin sequences.
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic clear_input_n_i = 1'b1;
	logic load_strobe_n_i = 1'b1;
	logic fs_n, sclk, sdi, sdo, sdo_oe, clear_mode;
	logic sdo_line; // Floats when the device does not drive it.
	logic [19:0] dac_code;
	logic [31:0] rd;
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;

	always #12.5 clk_sys_i = ~clk_sys_i;
	assign sdo_line = sdo_oe ? sdo : 1'bz;

	dac_update_clear_control i_dut (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .frame_select_n_i(fs_n),
		.serial_clk_i(sclk), .serial_data_i(sdi), .clear_input_n_i(clear_input_n_i),
		.load_strobe_n_i(load_strobe_n_i), .serial_data_o(sdo),
		.serial_data_oe_o(sdo_oe), .dac_code_o(dac_code), .clear_mode_o(clear_mode));

	host_serial_model i_host (.clk_i(clk_sys_i), .sdo_i(sdo_line), .frame_n_o(fs_n),
		.sclk_o(sclk), .sdi_o(sdi));

	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// A hung handshake ends the run after far more cycles than the tests need.
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			complete_run;
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_code(input logic [19:0] exp);
		check({12'h000, dac_code}, {12'h000, exp});
	endtask

	task automatic chk_mode(input logic exp);
		check({31'h0000_0000, clear_mode}, {31'h0000_0000, exp});
	endtask

	task automatic wr(input logic [6:0] a, input logic [23:0] d);
		i_host.frame({1'b0, a, d}, 32, 0, rd);
	endtask

	// A read answers in the following frame, so a zero no-op write follows it.
	task automatic rdchk(input logic [6:0] a, input logic [23:0] exp);
		i_host.frame({1'b1, a, 24'h00_0000}, 32, 0, rd);
		i_host.frame(32'h0000_0000, 32, 0, rd);
		check(rd, {1'b1, a, exp});
	endtask

	task automatic pulse_load;
		@(negedge clk_sys_i);
		load_strobe_n_i = 1'b0;
		repeat (4) @(negedge clk_sys_i);
		load_strobe_n_i = 1'b1;
		repeat (8) @(negedge clk_sys_i);
	endtask

	// Write a code with select held low after the last bit and look mid-tail.
	task automatic tail_write(input logic [19:0] code, input logic [19:0] mid);
		fork
			i_host.frame({1'b0, dac_ctrl_pkg::ADDR_CODE, code, 4'h0}, 32, 40, rd);
			begin
				repeat (276) @(negedge clk_sys_i);
				chk_code(mid);
			end
		join
	endtask

	initial begin
		repeat (20) @(negedge clk_sys_i);
		rst_i = 1'b0;
		repeat (4) @(negedge clk_sys_i);
		chk_code(20'h0_0000);
		rdchk(dac_ctrl_pkg::ADDR_PRIMARY_CONFIGURATION, 24'h00_4C80);
		// Default mode is synchronous: the buffer waits for a load pulse.
		wr(dac_ctrl_pkg::ADDR_CODE, 24'hAB_CDE0);
		chk_code(20'h0_0000);
		pulse_load;
		chk_code(20'hA_BCDE);
		rdchk(dac_ctrl_pkg::ADDR_CODE, 24'hAB_CDE0);
		// Software clear moves only the latch; a load with no new data keeps it.
		wr(dac_ctrl_pkg::ADDR_CLEAR, 24'h5A_0000);
		wr(dac_ctrl_pkg::ADDR_TRIGGER, 24'h00_0020);
		chk_code(20'h5_A000);
		rdchk(dac_ctrl_pkg::ADDR_TRIGGER, 24'h00_0000);
		pulse_load;
		chk_code(20'h5_A000);
		wr(dac_ctrl_pkg::ADDR_NOP, 24'h00_0000);
		rdchk(dac_ctrl_pkg::ADDR_CODE, 24'hAB_CDE0);
		// Reserved bits of the second configuration register read back as zero.
		wr(dac_ctrl_pkg::ADDR_SECONDARY_CONFIGURATION, 24'hFF_FFFF);
		rdchk(dac_ctrl_pkg::ADDR_SECONDARY_CONFIGURATION, dac_ctrl_pkg::SECONDARY_CONFIGURATION_WMASK);
		// Asynchronous mode with the chain on: update only at the frame end.
		wr(dac_ctrl_pkg::ADDR_PRIMARY_CONFIGURATION, 24'h00_0480);
		load_strobe_n_i = 1'b0;
		tail_write(20'h1_2345, 20'h5_A000);
		chk_code(20'h1_2345);
		// Chain off: update already at the last falling serial edge.
		wr(dac_ctrl_pkg::ADDR_PRIMARY_CONFIGURATION, 24'h00_0C80);
		tail_write(20'h5_4321, 20'h5_4321);
		// Clear pin dropped in mid-frame acts before the frame ends.
		fork
			i_host.frame({1'b0, dac_ctrl_pkg::ADDR_CODE, 24'h77_7770}, 32, 0, rd);
			begin
				repeat (100) @(negedge clk_sys_i);
				clear_input_n_i = 1'b0;
				repeat (8) @(negedge clk_sys_i);
				chk_code(20'h5_A000);
				chk_mode(1'b1);
			end
		join
		chk_code(20'h5_A000);
		clear_input_n_i = 1'b1;
		repeat (8) @(negedge clk_sys_i);
		chk_mode(1'b1);
		// A short frame is not a valid write and must not end clear mode.
		i_host.frame({1'b0, dac_ctrl_pkg::ADDR_CODE, 24'h11_1110}, 24, 0, rd);
		chk_mode(1'b1);
		wr(dac_ctrl_pkg::ADDR_CODE, 24'h22_2220);
		chk_mode(1'b0);
		chk_code(20'h2_2222);
		// Software reset brings every register back to its default.
		wr(dac_ctrl_pkg::ADDR_TRIGGER, 24'h00_0040);
		chk_code(20'h0_0000);
		rdchk(dac_ctrl_pkg::ADDR_PRIMARY_CONFIGURATION, 24'h00_4C80);
		rdchk(dac_ctrl_pkg::ADDR_CLEAR, 24'h00_0000);
		rdchk(dac_ctrl_pkg::ADDR_SECONDARY_CONFIGURATION, 24'h00_0000);
		complete_run;
	end
endmodule // tb
